/* File: src/bcs_regs.vh */
// constants and register map of the battery charge sequencer
// Summary of operation
// - power-up or battery insertion starts fast charge
// - fast charge drops to top-off when temperature or voltage leaves window
// - slope detection without thermistor falls back to voltage peak detection
// - fast charge also ends on temperature cut-off or time-out
// - full detection suppressed during hold-off at start of fast charge
// - top-off at reduced current ends at time-out or fixed duration
// - after top-off enter standby, regulation or trickle as initialized
// - standby regulation limits current and keeps watching temperature
// - trickle standby drives pulsed charge current
// - refresh pin low discharges until 1 V per cell, then fast charge
// - refresh accepted only while charging nickel batteries
// - init interval samples program pins, then timer pins drive LEDs
// - floating termination pin selects nickel charge with slope detection
// - standby ref tied to stabilized output or no thermistor selects trickle
// - standby ref grounded forces inhibit, highest priority from any state; a restart during inhibit still returns to init and clears timers
// - inhibit zeroes outputs, turns LEDs off, freezes timers
// - not low means floating, high or mid-level set
// - thermistor present when its voltage is below 3.3 V
// - thermistor present and standby ref floating or set selects regulation
// - time-out timer pauses in low voltage, temperature protection, inhibit
// - time-out is 2^26 oscillator periods times oscillator and time-out dividers
// - hold-off is 2^-5 of time-out
`ifndef BCS_REGS_VH
`define BCS_REGS_VH
// apb register offsets
`define BCS_CTRL_OFS 12'h000
`define BCS_STAT_OFS 12'h004
`define BCS_CFG_OFS 12'h008
`define BCS_TMR_OFS 12'h00C
// control fields
`define BCS_CTRL_RESTART 0
`define BCS_CTRL_RESET 32'h0000_0000
// pin level codes: 2'b00 low, 2'b01 floating, 2'b10 high, 2'b11 mid-level set
`define BCS_LVL_LOW 2'h0
`define BCS_LVL_FLT 2'h1
`define BCS_LVL_HIGH 2'h2
`define BCS_LVL_SET 2'h3
// timing exponents in oscillator periods
`define BCS_TIMEOUT_EXP 26
`define BCS_HOLDOFF_SHIFT 5
`define BCS_TOPOFF_EXP 27
`define BCS_INIT_EXP 14
`define BCS_TRICKLE_EXP 10
`endif

/* File: src/bcs_charge_sequencer.v */
// battery charge sequencer: method select, charge states, refresh, inhibit, apb status
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "bcs_regs.vh"
module bcs_charge_sequencer #(
  parameter OSC_DIV = 16,
  parameter TIMEOUT_EXP = `BCS_TIMEOUT_EXP,
  parameter TOPOFF_EXP = `BCS_TOPOFF_EXP,
  parameter INIT_EXP = `BCS_INIT_EXP,
  parameter TRICKLE_EXP = `BCS_TRICKLE_EXP
) (
  input wire ref_clk_in,
  input wire sys_rst_in,
  input wire battery_insert_in,
  input wire [1:0] standby_ref_input_in,
  input wire [1:0] termination_select_pin_in,
  input wire refresh_pin_in,
  input wire thermistor_present_in,
  input wire temp_window_ok_in,
  input wire volt_window_ok_in,
  input wire temp_cutoff_in,
  input wire temp_protect_in,
  input wire low_voltage_in,
  input wire slope_full_in,
  input wire voltage_peak_detect_in,
  input wire cell_at_1v_in,
  input wire [2:0] osc_divider_pin_in,
  input wire [2:0] timeout_divider_pin_in,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  output reg fast_charge_out,
  output reg topoff_charge_out,
  output reg trickle_pulse_out,
  output reg volt_regulate_out,
  output reg current_limit_out,
  output reg refresh_drive_out,
  output reg [2:0] state_led_out,
  output reg switched_ref_output_out,
  output reg program_pins_as_led_out
);
  localparam ST_INIT = 3'h0;
  localparam ST_FAST = 3'h1;
  localparam ST_TOPOFF = 3'h2;
  localparam ST_STBY = 3'h3;
  localparam ST_REFRESH = 3'h4;
  localparam ST_STOP = 3'h5;
  // 3-flop sync of all pin inputs; value accepted once stages 2 and 3 agree
  localparam NS = 21;
  wire [NS-1:0] raw;
  assign raw = {battery_insert_in, standby_ref_input_in, termination_select_pin_in,
    refresh_pin_in, thermistor_present_in, temp_window_ok_in, volt_window_ok_in,
    temp_cutoff_in, temp_protect_in, low_voltage_in, slope_full_in,
    voltage_peak_detect_in, cell_at_1v_in, osc_divider_pin_in, timeout_divider_pin_in};
  reg [NS-1:0] s1;
  reg [NS-1:0] s2;
  reg [NS-1:0] s3;
  reg [NS-1:0] pin;
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi = gi + 1)
    begin : g_sync
      always @(posedge ref_clk_in or posedge sys_rst_in)
      begin
        if (sys_rst_in)
        begin
          s1[gi] <= 1'b0;
          s2[gi] <= 1'b0;
          s3[gi] <= 1'b0;
          pin[gi] <= 1'b0;
        end
        else
        begin
          s1[gi] <= raw[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi])
            pin[gi] <= s3[gi];
        end
      end
    end
  endgenerate
  wire p_insert = pin[20];
  wire [1:0] p_stb = pin[19:18];
  wire [1:0] p_fct = pin[17:16];
  wire p_refresh_pin = pin[15];
  wire p_ntc = pin[14];
  wire p_twin = pin[13];
  wire p_vwin = pin[12];
  wire p_tcut = pin[11];
  wire p_tprot = pin[10];
  wire p_lowv = pin[9];
  wire p_slope = pin[8];
  wire p_peak = pin[7];
  wire p_1v = pin[6];
  wire [2:0] p_pod = pin[5:3];
  wire [2:0] p_ptd = pin[2:0];

  function not_low;
    input [1:0] lvl;
    begin
      not_low = (lvl != `BCS_LVL_LOW);
    end
  endfunction

  wire inhibit = ~not_low(p_stb);

  // prescaled tick: one per OSC_DIV clocks
  reg [15:0] presc;
  wire tick = (presc == OSC_DIV[15:0] - 16'h0001);
  always @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      presc <= 16'h0000;
    else if (!inhibit)
      presc <= tick ? 16'h0000 : presc + 16'h0001;
  end

  // apb: restart strobe re-runs the power-on sequence
  wire apb_wr = psel & penable & pwrite;
  wire ctrl_restart = apb_wr & (paddr == `BCS_CTRL_OFS) & pwdata[`BCS_CTRL_RESTART];
  reg insert_d;
  wire restart = ctrl_restart | (p_insert & ~insert_d);

  reg [2:0] state;
  reg [2:0] next_state;
  reg [35:0] t_out;
  reg [35:0] t_phase;
  reg slope_en;
  reg peak_en;
  reg trickle_sel;
  reg [2:0] pod_sel;
  reg [2:0] ptd_sel;
  reg last_done_bit;

  wire [35:0] timeout_len = ({35'h0, 1'b1} << TIMEOUT_EXP) * {33'h0, pod_sel} * {33'h0, ptd_sel};
  wire [35:0] holdoff_len = timeout_len >> `BCS_HOLDOFF_SHIFT;
  wire [35:0] topoff_len = ({35'h0, 1'b1} << TOPOFF_EXP) * {33'h0, pod_sel};
  wire [35:0] init_len = {35'h0, 1'b1} << INIT_EXP;
  wire timed_out = (t_out >= timeout_len);
  wire holdoff_over = (t_out >= holdoff_len);
  wire use_slope = slope_en & p_ntc;
  wire use_peak = peak_en | (slope_en & ~p_ntc);
  wire full = holdoff_over & ((use_slope & p_slope) | (use_peak & p_peak));
  wire tout_run = tick & ~p_lowv & ~p_tprot & ~inhibit;

  always @*
  begin
    next_state = state;
    case (state)
      ST_INIT:
        if (t_phase >= init_len)
          next_state = ST_FAST;
      ST_FAST:
        if (full | ~p_twin | ~p_vwin | p_tcut | timed_out)
          next_state = ST_TOPOFF;
      ST_TOPOFF:
        if (timed_out | (t_phase >= topoff_len) | p_lowv)
          next_state = ST_STBY;
      ST_STBY:
        if (!trickle_sel && p_tcut)
          next_state = ST_STOP;
      ST_REFRESH:
        if (p_1v)
          next_state = ST_FAST;
      ST_STOP:
        next_state = ST_STOP;
      default:
        next_state = ST_INIT;
    endcase
    if (!p_refresh_pin && not_low(p_fct) && (state == ST_FAST || state == ST_TOPOFF ||
        state == ST_STBY))
      next_state = ST_REFRESH;
  end

  always @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state <= ST_INIT;
      t_out <= 36'h0;
      t_phase <= 36'h0;
      slope_en <= 1'b1;
      peak_en <= 1'b0;
      trickle_sel <= 1'b1;
      pod_sel <= 3'h1;
      ptd_sel <= 3'h1;
      insert_d <= 1'b0;
    end
    else
    begin
      insert_d <= p_insert;
      if (restart)
      begin
        state <= ST_INIT;
        t_out <= 36'h0;
        t_phase <= 36'h0;
      end
      else if (!inhibit)
      begin
        if (state == ST_INIT)
        begin
          slope_en <= (p_fct == `BCS_LVL_FLT) | (p_fct == `BCS_LVL_HIGH);
          peak_en <= (p_fct != `BCS_LVL_FLT);
          trickle_sel <= (p_stb == `BCS_LVL_HIGH) | ~p_ntc;
          pod_sel <= (p_pod == 3'h0) ? 3'h1 : p_pod;
          ptd_sel <= (p_ptd == 3'h0) ? 3'h1 : p_ptd;
        end
        if (next_state != state)
        begin
          state <= next_state;
          t_phase <= 36'h0;
          if (next_state == ST_FAST)
            t_out <= 36'h0;
        end
        else
        begin
          if (tick)
            t_phase <= t_phase + 36'h1;
          if (tout_run && (state == ST_FAST || state == ST_TOPOFF))
            t_out <= t_out + 36'h1;
        end
      end
    end
  end

  always @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      last_done_bit <= 1'b0;
    else if (inhibit)
      last_done_bit <= 1'b0;
    else
      last_done_bit <= (state == ST_STOP);
  end

  always @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      fast_charge_out <= 1'b0;
      topoff_charge_out <= 1'b0;
      trickle_pulse_out <= 1'b0;
      volt_regulate_out <= 1'b0;
      current_limit_out <= 1'b0;
      refresh_drive_out <= 1'b0;
      state_led_out <= 3'h0;
      switched_ref_output_out <= 1'b0;
      program_pins_as_led_out <= 1'b0;
    end
    else if (inhibit)
    begin
      fast_charge_out <= 1'b0;
      topoff_charge_out <= 1'b0;
      trickle_pulse_out <= 1'b0;
      volt_regulate_out <= 1'b0;
      current_limit_out <= 1'b0;
      refresh_drive_out <= 1'b0;
      state_led_out <= 3'h0;
      switched_ref_output_out <= 1'b0;
      program_pins_as_led_out <= 1'b0;
    end
    else
    begin
      fast_charge_out <= (state == ST_FAST);
      topoff_charge_out <= (state == ST_TOPOFF);
      trickle_pulse_out <= (state == ST_STBY) & trickle_sel & t_phase[TRICKLE_EXP];
      volt_regulate_out <= (state == ST_STBY) & ~trickle_sel;
      current_limit_out <= (state == ST_STBY) & ~trickle_sel;
      refresh_drive_out <= (state == ST_REFRESH);
      program_pins_as_led_out <= (state != ST_INIT);
      switched_ref_output_out <= (state != ST_INIT);
      state_led_out <= (state == ST_INIT) ? 3'h0 : state;
    end
  end

  // single-cycle apb slave; unmapped addresses read zero and flag an error
  wire mapped = (paddr == `BCS_CTRL_OFS) | (paddr == `BCS_STAT_OFS) |
    (paddr == `BCS_CFG_OFS) | (paddr == `BCS_TMR_OFS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  always @*
  begin
    case (paddr)
      `BCS_STAT_OFS: prdata = {24'h0, last_done_bit, inhibit, p_ntc, 1'b0, timed_out,
        state};
      `BCS_CFG_OFS: prdata = {22'h0, ptd_sel, pod_sel, trickle_sel, peak_en, slope_en,
        1'b0};
      `BCS_TMR_OFS: prdata = t_out[35:4];
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule // bcs_charge_sequencer

/* File: tb/bcs_seq_properties.sv */
// port-level assertions for the charge sequencer
`timescale 1ns/1ps
module bcs_seq_properties (
  input wire ref_clk_in,
  input wire sys_rst_in,
  input wire [1:0] standby_ref_input_in,
  input wire temp_cutoff_in,
  input wire cell_at_1v_in,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire fast_charge_out,
  input wire topoff_charge_out,
  input wire trickle_pulse_out,
  input wire volt_regulate_out,
  input wire current_limit_out,
  input wire refresh_drive_out,
  input wire [2:0] state_led_out,
  input wire program_pins_as_led_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // four flops on each pin plus the output register, hence the run lengths
  property p_inh; (standby_ref_input_in == 2'h0) [*6] |-> {fast_charge_out, topoff_charge_out,
    trickle_pulse_out, volt_regulate_out, refresh_drive_out, state_led_out} == 8'h00; endproperty
  a_inh: assert property (p_inh) else $error("outputs active while inhibited");
  property p_one; $onehot0({fast_charge_out, topoff_charge_out, trickle_pulse_out,
    volt_regulate_out, refresh_drive_out}); endproperty
  a_one: assert property (p_one) else $error("two charge states at once");
  property p_lim; current_limit_out |-> volt_regulate_out; endproperty
  a_lim: assert property (p_lim) else $error("current limit outside regulation");
  property p_rdy; psel |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("bus wait state inserted");
  property p_err; psel && penable && paddr > 12'h00C |-> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_refresh_pin; (refresh_drive_out && cell_at_1v_in) [*6] |=> !refresh_drive_out; endproperty
  a_refresh_pin: assert property (p_refresh_pin) else $error("discharge past end voltage");
  property p_cut; (fast_charge_out && temp_cutoff_in) [*6] |=> !fast_charge_out; endproperty
  a_cut: assert property (p_cut) else $error("fast charge past cut-off");
  property p_init; $fell(sys_rst_in) |-> !(fast_charge_out || program_pins_as_led_out) [*8];
  endproperty
  a_init: assert property (p_init) else $error("init interval skipped");
  c_top: cover property (topoff_charge_out);
  c_trk: cover property (trickle_pulse_out);
  c_rf: cover property (refresh_drive_out);
endmodule // bcs_seq_properties
bind bcs_charge_sequencer bcs_seq_properties i_props (.ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in), .standby_ref_input_in(standby_ref_input_in),
  .temp_cutoff_in(temp_cutoff_in), .cell_at_1v_in(cell_at_1v_in), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .fast_charge_out(fast_charge_out), .topoff_charge_out(topoff_charge_out),
  .trickle_pulse_out(trickle_pulse_out), .volt_regulate_out(volt_regulate_out),
  .current_limit_out(current_limit_out), .refresh_drive_out(refresh_drive_out),
  .state_led_out(state_led_out), .program_pins_as_led_out(program_pins_as_led_out));

/* File: tb/bcs_pack_model.sv */
// battery pack stand-in: thermistor and cell voltage under discharge
`timescale 1ns/1ps
module bcs_pack_model #(
  parameter DRAIN_CYCLES = 24
) (
  input wire ref_clk_in,
  input wire drain_in,
  input wire ntc_fitted_in,
  output wire thermistor_present_out,
  output reg cell_at_1v_out = 1'b0
);
  integer depth = 0;
  assign thermistor_present_out = ntc_fitted_in;
  always @(posedge ref_clk_in)
  begin
    depth <= drain_in ? depth + 1 : 0;
    cell_at_1v_out <= drain_in && depth >= DRAIN_CYCLES;
  end
endmodule // bcs_pack_model

/* File: tb/bcs_charge_sequencer_bench.sv */
// self-checking bench for the charge sequencer
`timescale 1ns/1ps
module bcs_charge_sequencer_bench;
  reg ref_clk_in = 1'b0, sys_rst_in = 1'b1, battery_insert_in = 1'b0, refresh_pin_in = 1'b1;
  reg temp_window_ok_in = 1'b1, volt_window_ok_in = 1'b1, temp_cutoff_in = 1'b0;
  reg temp_protect_in = 1'b0, low_voltage_in = 1'b0, slope_full_in = 1'b0;
  reg voltage_peak_detect_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  reg [1:0] standby_ref_input_in = 2'h1, termination_select_pin_in = 2'h1;
  reg [2:0] osc_divider_pin_in = 3'h1, timeout_divider_pin_in = 3'h1;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  wire thermistor_present_in, cell_at_1v_in, pready, pslverr, fast_charge_out;
  wire topoff_charge_out, trickle_pulse_out, volt_regulate_out, current_limit_out;
  wire refresh_drive_out, switched_ref_output_out, program_pins_as_led_out;
  wire [2:0] state_led_out;
  wire [31:0] prdata;
  reg ntc_fitted = 1'b1;
  reg [31:0] sv;
  integer fails = 0, num_checks = 0, cycles = 0, i, hi;
  bcs_charge_sequencer #(.OSC_DIV(2), .TIMEOUT_EXP(8), .TOPOFF_EXP(9), .INIT_EXP(3),
    .TRICKLE_EXP(1)) i_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .battery_insert_in(battery_insert_in), .standby_ref_input_in(standby_ref_input_in),
    .termination_select_pin_in(termination_select_pin_in), .refresh_pin_in(refresh_pin_in),
    .thermistor_present_in(thermistor_present_in), .temp_window_ok_in(temp_window_ok_in),
    .volt_window_ok_in(volt_window_ok_in), .temp_cutoff_in(temp_cutoff_in),
    .temp_protect_in(temp_protect_in), .low_voltage_in(low_voltage_in),
    .slope_full_in(slope_full_in), .voltage_peak_detect_in(voltage_peak_detect_in),
    .cell_at_1v_in(cell_at_1v_in), .osc_divider_pin_in(osc_divider_pin_in),
    .timeout_divider_pin_in(timeout_divider_pin_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .fast_charge_out(fast_charge_out),
    .topoff_charge_out(topoff_charge_out), .trickle_pulse_out(trickle_pulse_out),
    .volt_regulate_out(volt_regulate_out), .current_limit_out(current_limit_out),
    .refresh_drive_out(refresh_drive_out), .state_led_out(state_led_out),
    .switched_ref_output_out(switched_ref_output_out),
    .program_pins_as_led_out(program_pins_as_led_out));
  bcs_pack_model i_pack (.ref_clk_in(ref_clk_in), .drain_in(refresh_drive_out),
    .ntc_fitted_in(ntc_fitted), .thermistor_present_out(thermistor_present_in),
    .cell_at_1v_out(cell_at_1v_in));
  always #4 ref_clk_in = ~ref_clk_in;
  task chk(input [31:0] got, input [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    @(posedge ref_clk_in);
    while (pready !== 1'b1)
      @(posedge ref_clk_in);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  // polls the state field at most 900 times, then checks it
  task ws(input [2:0] s);
  begin
    rd = 32'hFFFF_FFFF;
    for (i = 0; i < 900 && rd[2:0] !== s; i = i + 1)
      apb(1'b0, 12'h004, 32'h0);
    chk(rd[2:0], s);
  end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task conclude;
  begin
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  always @(posedge ref_clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      fails = fails + 1;
      conclude;
    end
  end
  initial
  begin
    idle(6);
    sys_rst_in <= 1'b0;
    ws(3'h1);
    idle(2);
    chk(program_pins_as_led_out, 1'b1);
    chk(switched_ref_output_out, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[2:1], 2'h1);
    chk(rd[3], 1'b0);
    $display("start test done");
    standby_ref_input_in <= 2'h0;
    idle(8);
    chk({fast_charge_out, refresh_drive_out, state_led_out}, 5'h00);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[6], 1'b1);
    // a running count would move by two in this span
    apb(1'b0, 12'h00C, 32'h0);
    sv = rd;
    idle(64);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, sv);
    standby_ref_input_in <= 2'h1;
    idle(8);
    ws(3'h1);
    $display("inhibit test done");
    refresh_pin_in <= 1'b0;
    ws(3'h4);
    idle(2);
    chk(refresh_drive_out, 1'b1);
    refresh_pin_in <= 1'b1;
    ws(3'h1);
    $display("refresh test done");
    // slope full seen at once after refresh must wait out the hold-off
    slope_full_in <= 1'b1;
    idle(4);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[2:0], 3'h1);
    ws(3'h2);
    slope_full_in <= 1'b0;
    ws(3'h3);
    idle(2);
    chk(volt_regulate_out, 1'b1);
    chk(current_limit_out, 1'b1);
    temp_cutoff_in <= 1'b1;
    ws(3'h5);
    temp_cutoff_in <= 1'b0;
    refresh_pin_in <= 1'b0;
    idle(8);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[2:0], 3'h5);
    refresh_pin_in <= 1'b1;
    $display("full test done");
    standby_ref_input_in <= 2'h2;
    battery_insert_in <= 1'b1;
    idle(6);
    battery_insert_in <= 1'b0;
    ws(3'h1);
    volt_window_ok_in <= 1'b0;
    ws(3'h2);
    volt_window_ok_in <= 1'b1;
    ws(3'h3);
    hi = 0;
    for (i = 0; i < 256; i = i + 1)
    begin
      @(posedge ref_clk_in);
      hi = hi + trickle_pulse_out;
    end
    chk(hi > 0 && hi < 256, 1'b1);
    $display("trickle test done");
    // no thermistor: slope programming falls back to peak, standby to trickle
    ntc_fitted <= 1'b0;
    standby_ref_input_in <= 2'h1;
    osc_divider_pin_in <= 3'h2;
    timeout_divider_pin_in <= 3'h2;
    idle(8);
    apb(1'b1, 12'h000, 32'h0000_0001);
    ws(3'h0);
    ws(3'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[9:4], 6'h12);
    chk(rd[3:1], 3'h5);
    // hold-off is 64 clocks with both dividers at two
    idle(80);
    voltage_peak_detect_in <= 1'b1;
    idle(8);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[2:0], 3'h2);
    voltage_peak_detect_in <= 1'b0;
    $display("no thermistor test done");
    apb(1'b1, 12'h000, 32'h0000_0001);
    ws(3'h1);
    temp_protect_in <= 1'b1;
    idle(6);
    apb(1'b0, 12'h00C, 32'h0);
    sv = rd;
    idle(64);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, sv);
    temp_protect_in <= 1'b0;
    idle(64);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd != sv, 1'b1);
    temp_cutoff_in <= 1'b1;
    idle(8);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[2:0], 3'h2);
    temp_cutoff_in <= 1'b0;
    $display("protection test done");
    apb(1'b0, 12'h010, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 12'h014, 32'hFFFF_FFFF);
    chk(er, 1'b1);
    $display("bus test done");
    conclude;
  end
endmodule // bcs_charge_sequencer_bench
